// ==== core/arp_pkg.sv ====
// Constants and types shared by the result port and its self-checking bench
package arp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register bus
   localparam int unsigned ADDR_W       = 8;
   localparam int unsigned DATA_W       = 32;
   localparam logic [7:0]  REG_STATUS   = 8'h00;
   localparam logic [7:0]  REG_INT_STAT = 8'h04;
   localparam logic [7:0]  REG_INT_MASK = 8'h08;
   localparam logic [7:0]  REG_RESULT   = 8'h0C;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status bit positions and reset values
   localparam int unsigned INT_W         = 3;
   localparam int unsigned INT_CONV_DONE = 0;
   localparam int unsigned INT_OVERRUN   = 1;
   localparam int unsigned INT_READ_DONE = 2;
   localparam logic [2:0]  INT_MASK_RST  = 3'h0;
   localparam logic [2:0]  INT_STAT_RST  = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Shared low data pins in serial mode
   localparam int unsigned PIN_W         = 8;
   localparam int unsigned PIN_DIV_LO    = 2;
   localparam int unsigned PIN_DIV_HI    = 3;
   localparam int unsigned PIN_CLK_SRC   = 4;
   localparam int unsigned PIN_SYNC_POL  = 5;
   localparam int unsigned PIN_CLK_INV   = 6;
   localparam int unsigned PIN_READ_MODE = 7;

   // Synchronised pin vector layout
   localparam int unsigned SYN_W        = 12;
   localparam int unsigned SYN_SCLK     = 8;
   localparam int unsigned SYN_RD_N     = 9;
   localparam int unsigned SYN_CS_N     = 10;
   localparam int unsigned SYN_PORT_SEL = 11;
   localparam logic [11:0] SYN_RST      = 12'h600;

   ////////////////////////////////////////////////////////////////////////////
   // Result framing
   localparam int unsigned RESULT_W   = 16;
   localparam int unsigned BIT_CNT_W  = 5;
   localparam logic [4:0]  FRAME_BITS = 5'h10;
   localparam logic [4:0]  LAST_BIT   = 5'h0F;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SCLK_HALF_NS  = 20;
   localparam logic [4:0]  SCLK_HALF_CYC =
      5'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      ARP_IDLE,
      ARP_MSHIFT,
      ARP_SSHIFT
   } arp_phase_t;

endpackage : arp_pkg

// ==== core/arp_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module arp_sync #(
   parameter int unsigned       WIDTH = 1,
   parameter logic [WIDTH-1:0]  INIT  = '0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Raw pins and filtered levels
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] level
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } arp_sync_t;

   arp_sync_t s;
   arp_sync_t next_s;

   ////////////////////////////////////////////////////////////////////////////
   // First stage feeds only the second
   always_comb begin
      next_s    = s;
      next_s.s1 = pinIn;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      for (int i = 0; i < int'(WIDTH); i++) begin
         if (s.s2[i] == s.s3[i]) begin
            next_s.lvl[i] = s.s3[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s <= {INIT, INIT, INIT, INIT};
      end else begin
         s <= next_s;
      end
   end

   assign level = s.lvl;

endmodule : arp_sync

// ==== core/arp_port.sv ====
// Converter result port: parallel low byte or serial master/slave port
`timescale 1ns/1ns
module arp_port (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   // Register port
   input  wire logic [arp_pkg::ADDR_W-1:0]   regAddr,
   input  wire logic [arp_pkg::DATA_W-1:0]   regWdata,
   input  wire logic                         regWrite,
   input  wire logic                         regRead,
   output logic      [arp_pkg::DATA_W-1:0]   regRdata,
   output logic                              irq,
   // Converter core
   input  wire logic                         convBusy,
   input  wire logic                         resultValid,
   input  wire logic [arp_pkg::RESULT_W-1:0] resultData,
   // Select pins
   input  wire logic                         portTypeSelect,
   input  wire logic                         chipSelect_b,
   input  wire logic                         readEnable_b,
   // Shared low data pins
   input  wire logic [arp_pkg::PIN_W-1:0]    dataPinIn,
   output logic      [arp_pkg::PIN_W-1:0]    dataPinOut,
   output logic      [arp_pkg::PIN_W-1:0]    dataPinOe,
   // Serial port pins
   output logic                              serialResultOut,
   output logic                              serialResultOe,
   input  wire logic                         shiftClockIn,
   output logic                              shiftClockOut,
   output logic                              shiftClockOe,
   output logic                              frameSyncOut,
   output logic                              frameSyncOe,
   output logic                              readOverrunFlag,
   output logic                              readOverrunOe
);
   import arp_pkg::*;

   typedef struct packed {
      arp_phase_t               phase;
      logic [RESULT_W-1:0]      shiftReg;
      logic [RESULT_W-1:0]      heldResult;
      logic [BIT_CNT_W-1:0]     bitCnt;
      logic [4:0]               divCnt;
      logic                     sclkInt;
      logic                     busyPrev;
      logic                     csPrev;
      logic                     sclkPrev;
      logic [PIN_W-1:0]         dataOut;
      logic [PIN_W-1:0]         dataOe;
      logic                     serOut;
      logic                     serOe;
      logic                     sclkOut;
      logic                     sclkOe;
      logic                     syncOut;
      logic                     syncOe;
      logic                     overrun;
      logic                     overrunOe;
      logic [INT_W-1:0]         intStat;
      logic [INT_W-1:0]         intMask;
      logic                     irq;
      logic [DATA_W-1:0]        rdata;
   } arp_state_t;

   arp_state_t s;
   arp_state_t next_s;

   logic [SYN_W-1:0] pinLvl;
   logic             serialSel;
   logic             clkSrc;
   logic             syncPol;
   logic             clkInv;
   logic             readMode;
   logic [1:0]       divSel;
   logic             csLvl_b;
   logic             rdLvl_b;
   logic             sclkLvl;
   logic             masterMode;
   logic             slaveMode;
   logic             racMode;
   logic             updateEdge;
   logic [4:0]       halfLen;

   ////////////////////////////////////////////////////////////////////////////
   // Half period of the internal clock in system cycles
   function automatic logic [4:0] halfCycles(input logic [1:0] div, input logic rac);
      logic [4:0] h;
      h = SCLK_HALF_CYC;
      if (rac) begin
         h = 5'(SCLK_HALF_CYC << div);
      end
      return h;
   endfunction : halfCycles

   arp_sync #(
      .WIDTH (SYN_W),
      .INIT  (SYN_RST)
   ) u_pinSync (
      .clk   (clk),
      .rst_b (rst_b),
      .pinIn ({portTypeSelect, chipSelect_b, readEnable_b, shiftClockIn, dataPinIn}),
      .level (pinLvl)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode from filtered pins
   // port type select
   assign serialSel  = pinLvl[SYN_PORT_SEL];
   assign clkSrc     = pinLvl[PIN_CLK_SRC];
   assign syncPol    = pinLvl[PIN_SYNC_POL];
   assign clkInv     = pinLvl[PIN_CLK_INV];
   assign readMode   = pinLvl[PIN_READ_MODE];
   assign divSel     = pinLvl[PIN_DIV_HI:PIN_DIV_LO];
   assign csLvl_b    = pinLvl[SYN_CS_N];
   assign rdLvl_b    = pinLvl[SYN_RD_N];
   assign sclkLvl    = pinLvl[SYN_SCLK];
   assign masterMode = serialSel && !clkSrc;
   assign slaveMode  = serialSel && clkSrc;
   assign racMode    = masterMode && !readMode;
   assign halfLen    = halfCycles(divSel, racMode);
   assign updateEdge = !csLvl_b && (clkInv ? (s.sclkPrev && !sclkLvl)
                                           : (!s.sclkPrev && sclkLvl));

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_s           = s;
      next_s.busyPrev  = convBusy;
      next_s.csPrev    = csLvl_b;
      next_s.sclkPrev  = sclkLvl;
      next_s.overrun   = 1'b0;
      next_s.rdata     = '0;

      if (resultValid) begin
         next_s.heldResult             = resultData;
         next_s.intStat[INT_CONV_DONE] = 1'b1;
      end

      case (s.phase)
         ARP_IDLE: begin
            if (masterMode && readMode && convBusy && !s.busyPrev) begin
               next_s.phase    = ARP_MSHIFT;
               next_s.shiftReg = s.heldResult;
               next_s.bitCnt   = '0;
               next_s.divCnt   = halfLen - 5'h01;
               next_s.sclkInt  = 1'b0;
            end else if (racMode && resultValid) begin
               next_s.phase    = ARP_MSHIFT;
               next_s.shiftReg = resultData;
               next_s.bitCnt   = '0;
               next_s.divCnt   = halfLen - 5'h01;
               next_s.sclkInt  = 1'b0;
            end else if (slaveMode && s.csPrev && !csLvl_b) begin
               next_s.phase    = ARP_SSHIFT;
               next_s.shiftReg = s.heldResult;
               next_s.bitCnt   = '0;
            end
         end
         ARP_MSHIFT: begin
            if (!masterMode) begin
               next_s.phase = ARP_IDLE;
            end else if (s.divCnt != 5'h00) begin
               next_s.divCnt = s.divCnt - 5'h01;
            end else begin
               next_s.divCnt  = halfLen - 5'h01;
               next_s.sclkInt = !s.sclkInt;
               // Data moves on the internal falling edge, so it is steady
               // across the rising edge the host samples on
               if (s.sclkInt) begin
                  if (s.bitCnt == LAST_BIT) begin
                     next_s.phase                  = ARP_IDLE;
                     next_s.intStat[INT_READ_DONE] = 1'b1;
                  end else begin
                     next_s.bitCnt   = s.bitCnt + 5'h01;
                     next_s.shiftReg = {s.shiftReg[RESULT_W-2:0], 1'b0};
                  end
               end
            end
         end
         ARP_SSHIFT: begin
            if (resultValid && s.bitCnt < FRAME_BITS) begin
               next_s.phase                = ARP_IDLE;
               next_s.overrun              = 1'b1;
               next_s.intStat[INT_OVERRUN] = 1'b1;
            end else if (!slaveMode || csLvl_b) begin
               next_s.phase = ARP_IDLE;
            end else if (updateEdge) begin
               next_s.shiftReg = {s.shiftReg[RESULT_W-2:0], readMode};
               if (s.bitCnt < FRAME_BITS) begin
                  next_s.bitCnt = s.bitCnt + 5'h01;
               end
               if (s.bitCnt == LAST_BIT) begin
                  next_s.intStat[INT_READ_DONE] = 1'b1;
               end
            end
         end
         default: begin
            next_s.phase = ARP_IDLE;
         end
      endcase

      // Pin drivers except the low byte follow the next state so the outputs stay registered
      // parallel low byte
      next_s.dataOut = s.heldResult[PIN_W-1:0];
      next_s.dataOe  = (!serialSel && !csLvl_b && !rdLvl_b) ? 8'hFF : 8'h00;
      next_s.serOut  = (next_s.phase == ARP_IDLE) ? 1'b0 : next_s.shiftReg[RESULT_W-1];
      next_s.serOe   = serialSel && !csLvl_b && !rdLvl_b;
      next_s.sclkOe  = masterMode;
      next_s.sclkOut = (next_s.phase == ARP_MSHIFT ? next_s.sclkInt : 1'b0) ^ clkInv;
      next_s.syncOe  = masterMode;
      next_s.syncOut = (next_s.phase == ARP_MSHIFT) ^ syncPol;
      next_s.overrunOe = slaveMode;

      // Register writes; a new event wins over a clear in the same cycle unless its bit was already set
      if (regWrite) begin
         case (regAddr)
            REG_INT_STAT: next_s.intStat = next_s.intStat &
                                           ~(regWdata[INT_W-1:0] & ~(next_s.intStat ^ s.intStat));
            REG_INT_MASK: next_s.intMask = regWdata[INT_W-1:0];
            default:      next_s.intMask = next_s.intMask;
         endcase
      end
      if (regRead) begin
         case (regAddr)
            REG_STATUS:   next_s.rdata = {19'h00000, s.bitCnt, 1'b0, s.phase, rdLvl_b,
                                          csLvl_b, readMode, clkSrc, serialSel};
            REG_INT_STAT: next_s.rdata = {29'h00000000, s.intStat};
            REG_INT_MASK: next_s.rdata = {29'h00000000, s.intMask};
            REG_RESULT:   next_s.rdata = {16'h0000, s.heldResult};
            default:      next_s.rdata = 32'h00000000;
         endcase
      end
      next_s.irq = |(next_s.intStat & next_s.intMask);
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s         <= '0;
         s.phase   <= ARP_IDLE;
         s.csPrev  <= 1'b1;
         s.intMask <= INT_MASK_RST;
         s.intStat <= INT_STAT_RST;
      end else begin
         s <= next_s;
      end
   end

   assign regRdata        = s.rdata;
   assign irq             = s.irq;
   assign dataPinOut      = s.dataOut;
   assign dataPinOe       = s.dataOe;
   assign serialResultOut = s.serOut;
   assign serialResultOe  = s.serOe;
   assign shiftClockOut   = s.sclkOut;
   assign shiftClockOe    = s.sclkOe;
   assign frameSyncOut    = s.syncOut;
   assign frameSyncOe     = s.syncOe;
   assign readOverrunFlag = s.overrun;
   assign readOverrunOe   = s.overrunOe;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_PAR_DATA: assert property (
      (!serialSel && !csLvl_b && !rdLvl_b) |=>
         (dataPinOe == 8'hFF && dataPinOut == $past(s.heldResult[7:0])))
      else $error("parallel low byte not driven");
   AST_SER_HIZ: assert property (
      serialSel |=> dataPinOe == 8'h00)
      else $error("shared pins driven in serial mode");
   AST_DIV_SLOW: assert property (
      (s.phase == ARP_MSHIFT && racMode && $stable(divSel) && s.divCnt == 5'h00
       && next_s.phase == ARP_MSHIFT) |=> s.divCnt == $past(halfLen) - 5'h01)
      else $error("divided half period wrong");
   AST_DIV_IGNORED: assert property (
      (serialSel && !racMode) |-> halfLen == SCLK_HALF_CYC)
      else $error("divider used outside read-after-convert");
   AST_MASTER_CLK: assert property (
      masterMode |=> shiftClockOe)
      else $error("master clock not driven");
   AST_SLAVE_GATE: assert property (
      (s.phase == ARP_SSHIFT && csLvl_b) |=> s.phase == ARP_IDLE)
      else $error("slave frame survives deselect");
   AST_SYNC_POL: assert property (
      masterMode |=> frameSyncOut == ((s.phase == ARP_MSHIFT) ^ $past(syncPol)))
      else $error("frame sync level wrong");
   AST_CLK_INV: assert property (
      (masterMode && s.phase == ARP_IDLE && next_s.phase == ARP_IDLE) |=>
         shiftClockOut == $past(clkInv))
      else $error("idle clock ignores invert");
   AST_CHAIN_IN: assert property (
      (s.phase == ARP_SSHIFT && slaveMode && !csLvl_b && updateEdge && !resultValid)
         |=> s.shiftReg[0] == $past(readMode))
      else $error("chain bit not captured");
   AST_CHAIN_OUT: assert property (
      (s.phase == ARP_SSHIFT && s.bitCnt == FRAME_BITS && !csLvl_b && slaveMode
       && updateEdge) |=> s.shiftReg[15] == $past(s.shiftReg[14]))
      else $error("chain data not forwarded");
   AST_RDC_START: assert property (
      (s.phase == ARP_IDLE && masterMode && readMode && convBusy && !s.busyPrev)
         |=> (s.phase == ARP_MSHIFT && s.shiftReg == $past(s.heldResult)))
      else $error("previous result not shifted");
   AST_RAC_WAIT: assert property (
      (s.phase == ARP_IDLE && racMode && !resultValid) |=> s.phase == ARP_IDLE)
      else $error("master frame before completion");
   // Second cycle only while serial holds, a return to parallel may drive again
   AST_HIZ_CFG: assert property (
      (serialSel && s.phase == ARP_IDLE) ##1 serialSel |=> dataPinOe == 8'h00)
      else $error("config pins driven");
   AST_FRAME_SYNC: assert property (
      (masterMode && s.phase == ARP_MSHIFT && $stable(syncPol)) |->
         frameSyncOut == !syncPol)
      else $error("sync inactive in frame");
   AST_SLAVE_HOLD: assert property (
      (s.phase == ARP_SSHIFT && slaveMode && !csLvl_b && !updateEdge && !resultValid)
         |=> $stable(s.shiftReg))
      else $error("slave data moved off edge");
   AST_OVERRUN: assert property (
      (s.phase == ARP_SSHIFT && resultValid && s.bitCnt < FRAME_BITS) |=>
         (readOverrunFlag && s.phase == ARP_IDLE) ##1 !readOverrunFlag)
      else $error("overrun not flagged");

   COV_MASTER_FRAME: cover property (s.phase == ARP_MSHIFT ##1 s.phase == ARP_IDLE);
   COV_SLAVE_DONE: cover property (s.phase == ARP_SSHIFT && s.bitCnt == FRAME_BITS);
   COV_OVERRUN: cover property (readOverrunFlag);
   COV_IRQ: cover property ($rose(irq));

endmodule : arp_port

// ==== verif/arp_host_model.sv ====
// Host model: slave shift clock source and result sampler
`timescale 1ns/1ns
module arp_host_model (
   // Clock and control
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic        inv,
   input  wire logic [5:0]  nPer,
   // Serial pins
   input  wire logic        sdo,
   output logic             sclk,
   output logic             busy,
   output logic [31:0]      word
);
   ////////////////////////////////////////
   // host clock, still between frames
   initial begin
      busy = 1'h0;
      word = 32'h0;
      sclk = 1'h1;
      forever begin
         @(posedge clk);
         sclk <= !inv;
         if (go) begin
            busy <= 1'h1;
            repeat (8) @(posedge clk);
            for (int i = 0; i < nPer; i++) begin
               sclk <= inv;
               word <= {word[30:0], sdo};
               // Six cycles a level: design filters the pin
               repeat (6) @(posedge clk);
               sclk <= !inv;
               repeat (6) @(posedge clk);
            end
            busy <= 1'h0;
         end
      end
   end
endmodule : arp_host_model

// ==== verif/arp_port_test.sv ====
// Self-checking bench of the converter result port
`timescale 1ns/1ns
module arp_port_test;
   import arp_pkg::*;
   ////////////////////////////////////////
   logic                clk, rst_b, regWrite, regRead, irq, convBusy, resultValid;
   logic [ADDR_W-1:0]   regAddr;
   logic [DATA_W-1:0]   regWdata, regRdata, r;
   logic [RESULT_W-1:0] resultData, lastRes;
   logic [PIN_W-1:0]    dataPinIn, dataPinOut, dataPinOe;
   logic                portTypeSelect, chipSelect_b, readEnable_b, shiftClockIn;
   logic                serialResultOut, serialResultOe, shiftClockOut, shiftClockOe;
   logic                frameSyncOut, frameSyncOe, readOverrunFlag, readOverrunOe;
   logic                src, pol, inv, chain, hostGo, hostBusy, sk, ovr;
   logic [1:0]          div;
   logic [5:0]          hostPer;
   logic [31:0]         hostWord, rx, seed;
   int                  errors, comparisons, edges, per, lastEdge;

   assign dataPinIn = {chain, inv, pol, src, div, 2'h0};

   arp_port i_arp_port (
      .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq),
      .convBusy(convBusy), .resultValid(resultValid), .resultData(resultData),
      .portTypeSelect(portTypeSelect), .chipSelect_b(chipSelect_b),
      .readEnable_b(readEnable_b), .dataPinIn(dataPinIn), .dataPinOut(dataPinOut),
      .dataPinOe(dataPinOe), .serialResultOut(serialResultOut),
      .serialResultOe(serialResultOe), .shiftClockIn(shiftClockIn),
      .shiftClockOut(shiftClockOut), .shiftClockOe(shiftClockOe),
      .frameSyncOut(frameSyncOut), .frameSyncOe(frameSyncOe),
      .readOverrunFlag(readOverrunFlag), .readOverrunOe(readOverrunOe));
   arp_host_model i_arp_host_model (
      .clk(clk), .go(hostGo), .inv(inv), .nPer(hostPer), .sdo(serialResultOut),
      .sclk(shiftClockIn), .busy(hostBusy), .word(hostWord));

   initial begin
      clk = 1'h0;
      forever #5 clk = !clk;
   end

   ////////////////////////////////////////
   // master bits taken only inside the frame
   always @(posedge clk) begin
      sk <= shiftClockOut ^ inv;
      per <= per + 1;
      if (readOverrunFlag) ovr <= 1'h1;
      if ((frameSyncOut ^ pol) && (shiftClockOut ^ inv) && !sk) begin
         rx <= {rx[30:0], serialResultOut};
         edges <= edges + 1;
         lastEdge <= per;
         per <= 1;
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   function automatic int expPeriod(input logic rm, input logic [1:0] d);
      return rm ? 4 : 4 << d;
   endfunction : expPeriod

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'h1;
      @(posedge clk);
      regWrite <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'h1;
      @(posedge clk);
      regRead <= 1'h0;
      @(negedge clk);
      d = regRdata;
   endtask : rd
   task automatic conv();
      seed = xs(seed);
      @(posedge clk);
      convBusy <= 1'h1;
      tick(3);
      resultValid <= 1'h1;
      resultData <= seed[15:0];
      convBusy <= 1'h0;
      lastRes = seed[15:0];
      @(posedge clk);
      resultValid <= 1'h0;
   endtask : conv
   task automatic mode(input logic s, c, ch, input logic [1:0] d, input logic p, v);
      @(posedge clk);
      portTypeSelect <= s;
      src <= c;
      chain <= ch;
      div <= d;
      pol <= p;
      inv <= v;
      // Pins pass a filter before the mode is seen
      tick(10);
   endtask : mode
   task automatic master(input logic rm, input logic [1:0] d, input logic p, v);
      logic [15:0] prev;
      int n;
      // master, chain pin as read mode
      mode(1'h1, 1'h0, rm, d, p, v);
      prev = lastRes;
      edges = 0;
      conv();
      for (n = 0; n < 1000 && edges < 16; n++) tick(1);
      tick(40);
      chk(edges, 32'h10, "bit count");
      chk(rx[15:0], rm ? prev : lastRes, "master word");
      chk(lastEdge, expPeriod(rm, d), "period");
      chk({shiftClockOe, frameSyncOe, readOverrunOe, serialResultOe}, 4'hD, "oe");
      chk({shiftClockOut, frameSyncOut}, {v, p}, "idle");
   endtask : master
   task automatic slave(input logic v, input logic [5:0] np);
      logic [15:0] prev;
      int n;
      seed = xs(seed);
      // deselect first: a read starts only on a falling select
      chipSelect_b <= 1'h1;
      mode(1'h1, 1'h1, seed[20], 2'h3, 1'h0, v);
      conv();
      prev = lastRes;
      hostPer <= np;
      chipSelect_b <= 1'h0;
      tick(2);
      hostGo <= 1'h1;
      tick(1);
      hostGo <= 1'h0;
      tick(2);
      for (n = 0; n < 1000 && hostBusy; n++) tick(1);
      chk({shiftClockOe, frameSyncOe, readOverrunOe, serialResultOe}, 4'h3, "oe");
      ovr = 1'h0;
      conv();
      tick(8);
      chk(ovr, np < 6'h10, "overrun");
      if (np == 6'h20) chk(hostWord, {prev, {16{chain}}}, "slave word");
   endtask : slave

   task automatic print_verdict();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   // Longest path is eight master frames, three of them divided: far below this
   initial begin
      #500000;
      errors++;
      print_verdict();
   end

   initial begin
      {rst_b, regWrite, regRead, convBusy, resultValid, hostGo} = 6'h0;
      {portTypeSelect, src, pol, inv, chain, div, readEnable_b} = 8'h0;
      {regAddr, regWdata, resultData, rx, sk, ovr} = '0;
      chipSelect_b = 1'h1;
      hostPer = 6'h20;
      seed = 32'hA133;
      {errors, comparisons, edges, per, lastEdge} = '0;
      tick(4);
      rst_b <= 1'h1;
      tick(6);
      rd(REG_INT_MASK, r);
      chk(r, INT_MASK_RST, "mask reset");
      rd(8'h10, r);
      chk(r, 32'h0, "unmapped");
      chipSelect_b <= 1'h0;
      mode(1'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0);
      conv();
      tick(6);
      chk(dataPinOut, lastRes[7:0], "low byte");
      chk(dataPinOe, 8'hFF, "parallel oe");
      rd(REG_RESULT, r);
      chk(r, {16'h0000, lastRes}, "result");
      readEnable_b <= 1'h1;
      tick(6);
      chk(dataPinOe, 8'h00, "read gate");
      readEnable_b <= 1'h0;
      wr(REG_INT_MASK, 32'h1);
      tick(2);
      chk(irq, 1'h1, "irq done");
      mode(1'h1, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0);
      chk(dataPinOe[1:0], 2'h0, "low pins float");
      chk(dataPinOe[7:2], 6'h0, "config pins");
      rd(REG_STATUS, r);
      chk(r, 32'h1, "status serial");
      wr(REG_INT_STAT, 32'h7);
      wr(REG_INT_MASK, 32'h2);
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         master(i[2], i[2] ? seed[1:0] : i[1:0], i[0], i[1]);
      end
      slave(1'h0, 6'h20);
      slave(1'h1, 6'h20);
      chk(irq, 1'h0, "irq masked");
      slave(seed[0], 6'h6);
      chk(irq, 1'h1, "irq overrun");
      rd(REG_INT_STAT, r);
      chk(r[INT_OVERRUN], 1'h1, "stat overrun");
      wr(REG_INT_STAT, 32'h2);
      tick(2);
      chk(irq, 1'h0, "irq clear");
      print_verdict();
   end
endmodule : arp_port_test
